// file: common/csr_pkg.sv
// What this block does
// - Bit 4 reads aux clock present
// - Bit 5 reads oscillator clock present
// - Bit 6 reads PLL locked
// - Bit 7 low powers down; resets high
// - Bit 8 low asserts reset or hold
// - Test modes only when bit 9 set
// - Bits 10-12 read-only revision, writes ignored
// - Test mode plus bit 13 disables I/O blocks
// - Status code 1000 shows active reference
// - Status code 0000 shows reference detector
// - Bits 25/26 read reference activity flags
// - Divider codes for divide 1 to 5
// - Prescaled codes divide 4 to 80 with lag
// - Feedback divider uses same encoding
// - Mode pin low selects pin configuration
// - Pins sampled at power-up or leaving power-down
// - Pin one swaps dividers; aux pin steers mux
// - Pin two picks output buffer type field
// - Two-bit reference input buffer type
// - Bits 2-3 choose reference under internal control
// - External pin chooses; oscillator override wins
// - Hold select high means hold, low reset
package csr_pkg;

  localparam int REG_W = 28;
  localparam int FRAME_W = 32;
  localparam int ADDR_W = 4;
  localparam logic [5:0] FRAME_BITS = 6'h20;

  // Register addresses carried in the frame's low nibble
  localparam logic [3:0] OFF_REF_CFG = 4'h0;
  localparam logic [3:0] OFF_OUT1_CFG = 4'h1;
  localparam logic [3:0] OFF_FB_CFG = 4'hb;
  localparam logic [3:0] OFF_STAT = 4'hc;
  localparam logic [3:0] OFF_READ_CMD = 4'he;

  // Reset values
  localparam logic [27:0] RST_REF_CFG = 28'h0000000;
  localparam logic [27:0] RST_OUT1_CFG = 28'h0000000;
  localparam logic [27:0] RST_FB_CFG = 28'h0000000;
  localparam logic [27:0] RST_STAT = 28'h0000180;
  // Bit 16 is reserved and reads 0; bits 17-24 hold the status select and test fields
  localparam logic [27:0] STAT_WR_MASK = 28'h1fee380;

  // Status and control register fields
  localparam int B_AUX_PRES = 4;
  localparam int B_OSC_PRES = 5;
  localparam int B_LOCK = 6;
  localparam int B_PD_N = 7;
  localparam int B_RST_HOLD_N = 8;
  localparam int B_TEST_MODE_ENABLE = 9;
  localparam int B_REV_LO = 10;
  localparam int B_IO_DIS = 13;
  localparam int B_STAT_SEL_LO = 17;
  localparam int B_PRI_ACT = 25;
  localparam int B_SEC_ACT = 26;

  // Reference configuration fields
  localparam int B_IN_TYPE_X = 0;
  localparam int B_IN_TYPE_Y = 1;
  localparam int B_PRI_CHOOSE = 2;
  localparam int B_SEC_CHOOSE = 3;
  localparam int B_OSC_OVR = 4;
  localparam int B_REF_SRC = 5;
  localparam int B_OBUF_LX = 24;
  localparam int B_OBUF_LY = 25;
  localparam int B_OBUF_HX = 26;
  localparam int B_OBUF_HY = 27;

  // Divider fields
  localparam int B_OUT_DIV_LO = 13;
  localparam int B_FB_DIV_LO = 5;
  localparam int B_OUT_MUX = 21;
  localparam int B_HOLD_SEL = 25;

  // Status pin selections
  localparam logic [3:0] STAT_SEL_REFDET = 4'h0;
  localparam logic [3:0] STAT_SEL_ACTREF = 4'h8;

  // Buffer type codes {X,Y}
  localparam logic [1:0] OBUF_LVCMOS = 2'h0;
  localparam logic [1:0] OBUF_LVPECL = 2'h1;
  localparam logic [1:0] OBUF_DISABLE = 2'h2;
  localparam logic [1:0] OBUF_LVDS = 2'h3;
  localparam logic [1:0] IBUF_LVCMOS = 2'h0;
  localparam logic [1:0] IBUF_LVPECL = 2'h2;
  localparam logic [1:0] IBUF_LVDS = 2'h3;

  // Divider encoding: top two select bits
  localparam logic [1:0] DIV_TOP_PRESCALE = 2'h0;
  localparam logic [1:0] DIV_TOP_BYPASS = 2'h1;
  localparam logic [1:0] DIV_TOP_SMALL = 2'h2;
  localparam logic [7:0] LAG_BASE0 = 8'h1d;
  localparam logic [7:0] LAG_BASE1 = 8'h2a;
  localparam logic [7:0] LAG_BASE2 = 8'h39;
  localparam logic [7:0] LAG_BASE3 = 8'h46;

  typedef enum logic [1:0] {
    CSR_SPI_IDLE = 2'b01,
    CSR_SPI_SHIFT = 2'b10
  } csr_spi_e;

  typedef struct packed {
    logic aux_clock_present;
    logic osc_clock_present;
    logic pll_locked;
    logic primary_ref_activity;
    logic secondary_ref_activity;
    logic ref_freq_detect;
    logic active_ref_primary;
  } csr_stat_s;

  typedef struct packed {
    logic pri_en;
    logic sec_en;
    logic auto_sel;
    logic osc_sel;
  } csr_refsel_s;

  // Lag is counted in half cycles of the divide-by-one clock
  typedef struct packed {
    logic valid;
    logic [6:0] ratio;
    logic [7:0] lag_half;
  } csr_div_s;

  function automatic logic [6:0] div_field(input logic [27:0] word, input int lo);
    div_field = word[lo +: 7];
  endfunction

endpackage

// file: core/csr_div_decode.sv
`timescale 1ns/1ps
module csr_div_decode
  import csr_pkg::*;
(
  // Divider select code
  input wire logic [6:0] sel,
  // Decoded ratio and lag
  output csr_div_s dec
);
  wire [1:0] top = sel[6:5];
  wire [2:0] grp = sel[4:2];
  wire [1:0] idx = sel[1:0];
  wire [7:0] lag_base = (idx == 2'h0) ? LAG_BASE0 :
                        (idx == 2'h1) ? LAG_BASE1 :
                        (idx == 2'h2) ? LAG_BASE2 : LAG_BASE3;
  wire [7:0] step = (8'(idx) + 8'h02) * 8'h02;
  wire [7:0] pre_ratio = (8'(grp) + 8'h01) * step;
  wire [7:0] pre_lag = lag_base + 8'(grp) * step;
  wire is_pre = (top == DIV_TOP_PRESCALE);
  wire is_one = (top == DIV_TOP_BYPASS) && (sel[4:0] == 5'h00);
  wire is_small = (top == DIV_TOP_SMALL) && (grp == 3'h0);

  // Even small divides lag by half a cycle, odd ones do not
  assign dec.valid = is_pre | is_one | is_small;
  assign dec.ratio = is_pre ? pre_ratio[6:0] :
                     is_one ? 7'h01 :
                     is_small ? 7'(8'(idx) + 8'h02) : 7'h00;
  assign dec.lag_half = is_pre ? pre_lag :
                        (is_small && !idx[0]) ? 8'h01 : 8'h00;
endmodule // csr_div_decode

// file: core/csr_regs.sv
`timescale 1ns/1ps
module csr_regs
  import csr_pkg::*;
#(
  parameter logic [2:0] REVISION = 3'h0 // Arbitrary value
)(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Serial link, doubling as configuration pins
  input wire logic MODE_SELECT,
  input wire logic SPI_CLK,
  input wire logic SPI_LE,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  // Static control pins
  input wire logic AUX_SEL,
  input wire logic REF_SEL,
  input wire logic PD_PIN_N,
  // Live status from the clock core
  input csr_stat_s STAT_IN,
  // Controls to the clock core
  output logic STATUS_PIN,
  output logic POWER_DOWN,
  output logic RESET_ASSERT,
  output logic HOLD_ASSERT,
  output logic TEST_MODE_EN,
  output logic IO_BLOCK_DISABLE,
  output csr_refsel_s REF_SEL_OUT,
  output logic [1:0] REF_INPUT_TYPE,
  output logic [1:0] OUT_BUFFER_TYPE,
  output logic DIVIDER_SWAP,
  output logic AUX_MUX_SEL,
  output csr_div_s OUT_DIV,
  output csr_div_s FB_DIV
);

  csr_spi_e state_reg, state_next;
  logic [27:0] ref_cfg_reg, out1_cfg_reg, fb_cfg_reg, stat_reg;
  logic [31:0] shift_reg, rd_shift_reg;
  logic [5:0] cnt_reg;
  logic [3:0] rd_addr_reg;
  logic sclk_reg, le_reg, first_reg, pwr_up_reg;
  logic cd_swap_reg, cd_buf_reg, cd_aux_reg;
  csr_div_s out_dec, fb_dec;

  // Pin mode turns the serial pins into static configuration pins
  wire cd_mode = !MODE_SELECT;
  wire sclk_rise = SPI_CLK && !sclk_reg;
  wire sclk_fall = !SPI_CLK && sclk_reg;
  wire le_rise = SPI_LE && !le_reg;
  wire le_fall = !SPI_LE && le_reg;
  wire in_shift = (state_reg == CSR_SPI_SHIFT);

  // A short frame is dropped rather than written half-filled
  wire wr_en = in_shift && le_rise && (cnt_reg == FRAME_BITS) && !cd_mode;
  wire [3:0] wr_addr = shift_reg[3:0];
  wire [27:0] wr_data = shift_reg[31:4];

  // Live status merged into the control bits
  wire [27:0] stat_view = (stat_reg & STAT_WR_MASK)
    | (28'(STAT_IN.aux_clock_present) << B_AUX_PRES)
    | (28'(STAT_IN.osc_clock_present) << B_OSC_PRES)
    | (28'(STAT_IN.pll_locked) << B_LOCK)
    | (28'(REVISION) << B_REV_LO)
    | (28'(STAT_IN.primary_ref_activity) << B_PRI_ACT)
    | (28'(STAT_IN.secondary_ref_activity) << B_SEC_ACT);

  wire [27:0] rd_data = (rd_addr_reg == OFF_REF_CFG) ? ref_cfg_reg :
                        (rd_addr_reg == OFF_OUT1_CFG) ? out1_cfg_reg :
                        (rd_addr_reg == OFF_FB_CFG) ? fb_cfg_reg :
                        (rd_addr_reg == OFF_STAT) ? stat_view : 28'h0000000;
  wire [31:0] rd_word = {rd_data, rd_addr_reg};

  // Pin sampling only at power-up or on leaving power-down
  wire pwr_up = PD_PIN_N && stat_reg[B_PD_N];
  wire cd_sample = first_reg || (pwr_up && !pwr_up_reg);

  // Decoded controls
  wire test_mode_enable = stat_reg[B_TEST_MODE_ENABLE];
  wire hold_sel = fb_cfg_reg[B_HOLD_SEL];
  wire rh_on = !stat_reg[B_RST_HOLD_N];
  wire [3:0] stat_sel = stat_reg[B_STAT_SEL_LO +: 4];
  wire status_next = (stat_sel == STAT_SEL_ACTREF) ? STAT_IN.active_ref_primary :
                     (stat_sel == STAT_SEL_REFDET) ? STAT_IN.ref_freq_detect : 1'b0;
  wire osc_ovr = ref_cfg_reg[B_OSC_OVR];
  wire ref_src = ref_cfg_reg[B_REF_SRC];
  wire pri_pick = ref_src ? ref_cfg_reg[B_PRI_CHOOSE] : REF_SEL;
  wire sec_pick = ref_src ? ref_cfg_reg[B_SEC_CHOOSE] : !REF_SEL;
  csr_refsel_s refsel_next;
  assign refsel_next.osc_sel = osc_ovr;
  assign refsel_next.pri_en = !osc_ovr && pri_pick;
  assign refsel_next.sec_en = !osc_ovr && sec_pick;
  assign refsel_next.auto_sel = !osc_ovr && ref_src && pri_pick && sec_pick;
  wire buf_pin = cd_mode && cd_buf_reg;
  wire [1:0] obuf_next = buf_pin ? {ref_cfg_reg[B_OBUF_HX], ref_cfg_reg[B_OBUF_HY]} :
                                   {ref_cfg_reg[B_OBUF_LX], ref_cfg_reg[B_OBUF_LY]};
  wire [1:0] ibuf_next = {ref_cfg_reg[B_IN_TYPE_X], ref_cfg_reg[B_IN_TYPE_Y]};

  csr_div_decode u_out_dec (
    .sel(div_field(out1_cfg_reg, B_OUT_DIV_LO)),
    .dec(out_dec)
  );

  csr_div_decode u_fb_dec (
    .sel(div_field(fb_cfg_reg, B_FB_DIV_LO)),
    .dec(fb_dec)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CSR_SPI_IDLE: begin
        if (le_fall && !cd_mode) begin
          state_next = CSR_SPI_SHIFT;
        end
      end
      CSR_SPI_SHIFT: begin
        if (le_rise || cd_mode) begin
          state_next = CSR_SPI_IDLE;
        end
      end
      default: state_next = CSR_SPI_IDLE;
    endcase
  end

  // Link framing
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= CSR_SPI_IDLE;
      sclk_reg <= 1'b0;
      le_reg <= 1'b1;
      cnt_reg <= 6'h00;
      shift_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      sclk_reg <= SPI_CLK;
      le_reg <= SPI_LE;
      if (le_fall) begin
        cnt_reg <= 6'h00;
      end else if (in_shift && sclk_rise && cnt_reg != FRAME_BITS) begin
        cnt_reg <= cnt_reg + 6'h01;
        shift_reg <= {SPI_MOSI, shift_reg[31:1]};
      end
    end
  end

  // Readback shifts out least significant bit first on falling clock
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_shift_reg <= 32'h00000000;
      rd_addr_reg <= OFF_STAT;
      SPI_MISO <= 1'b0;
    end else begin
      if (le_fall && !cd_mode) begin
        SPI_MISO <= rd_word[0];
        rd_shift_reg <= {1'b0, rd_word[31:1]};
      end else if (in_shift && sclk_fall) begin
        SPI_MISO <= rd_shift_reg[0];
        rd_shift_reg <= {1'b0, rd_shift_reg[31:1]};
      end
      if (wr_en && wr_addr == OFF_READ_CMD) begin
        rd_addr_reg <= wr_data[3:0];
      end
    end
  end

  // Register writes; status and read-only bits are masked
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ref_cfg_reg <= RST_REF_CFG;
      out1_cfg_reg <= RST_OUT1_CFG;
      fb_cfg_reg <= RST_FB_CFG;
      stat_reg <= RST_STAT;
    end else if (wr_en) begin
      if (wr_addr == OFF_REF_CFG) ref_cfg_reg <= wr_data;
      if (wr_addr == OFF_OUT1_CFG) out1_cfg_reg <= wr_data;
      if (wr_addr == OFF_FB_CFG) fb_cfg_reg <= wr_data;
      if (wr_addr == OFF_STAT) stat_reg <= wr_data & STAT_WR_MASK;
    end
  end

  // Configuration pins latched at power-up or on leaving power-down, other wiggles ignored
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      first_reg <= 1'b1;
      pwr_up_reg <= 1'b0;
      cd_swap_reg <= 1'b0;
      cd_buf_reg <= 1'b0;
      cd_aux_reg <= 1'b0;
    end else begin
      first_reg <= 1'b0;
      pwr_up_reg <= pwr_up;
      if (cd_sample && cd_mode) begin
        cd_swap_reg <= SPI_CLK;
        cd_buf_reg <= SPI_MOSI;
        cd_aux_reg <= AUX_SEL;
      end
    end
  end

  // Registered controls
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      STATUS_PIN <= 1'b0;
      POWER_DOWN <= 1'b0;
      RESET_ASSERT <= 1'b0;
      HOLD_ASSERT <= 1'b0;
      TEST_MODE_EN <= 1'b0;
      IO_BLOCK_DISABLE <= 1'b0;
      REF_SEL_OUT <= '0;
      REF_INPUT_TYPE <= IBUF_LVCMOS;
      OUT_BUFFER_TYPE <= OBUF_LVCMOS;
      DIVIDER_SWAP <= 1'b0;
      AUX_MUX_SEL <= 1'b0;
      OUT_DIV <= '0;
      FB_DIV <= '0;
    end else begin
      STATUS_PIN <= status_next;
      POWER_DOWN <= !pwr_up;
      RESET_ASSERT <= rh_on && !hold_sel;
      HOLD_ASSERT <= rh_on && hold_sel;
      TEST_MODE_EN <= test_mode_enable;
      IO_BLOCK_DISABLE <= test_mode_enable && stat_reg[B_IO_DIS];
      REF_SEL_OUT <= refsel_next;
      REF_INPUT_TYPE <= ibuf_next;
      OUT_BUFFER_TYPE <= obuf_next;
      DIVIDER_SWAP <= cd_mode && cd_swap_reg;
      AUX_MUX_SEL <= cd_mode ? cd_aux_reg : fb_cfg_reg[B_OUT_MUX];
      OUT_DIV <= out_dec;
      FB_DIV <= fb_dec;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  pd_write_a: assert property (
    wr_en && wr_addr == OFF_STAT && !wr_data[B_PD_N] |-> ##2 POWER_DOWN
  ) else $error("power-down bit cleared but device stays up");

  hold_select_a: assert property (
    wr_en && wr_addr == OFF_STAT && !wr_data[B_RST_HOLD_N] && hold_sel
    |-> ##2 (HOLD_ASSERT && !RESET_ASSERT)
  ) else $error("hold selected but reset asserted");

  reset_select_a: assert property (
    wr_en && wr_addr == OFF_STAT && !wr_data[B_RST_HOLD_N] && !hold_sel
    |-> ##2 (RESET_ASSERT && !HOLD_ASSERT)
  ) else $error("reset selected but not asserted");

  io_gate_a: assert property (
    IO_BLOCK_DISABLE |-> TEST_MODE_EN && $past(stat_reg[B_IO_DIS])
  ) else $error("io blocks disabled outside test mode");

  revision_ro_a: assert property (
    wr_en && wr_addr == OFF_STAT
    |=> (stat_reg & ~STAT_WR_MASK) == 28'h0000000 && stat_view[B_REV_LO +: 3] == REVISION
  ) else $error("revision field changed by a write");

  actref_pin_a: assert property (
    stat_sel == STAT_SEL_ACTREF |=> STATUS_PIN == $past(STAT_IN.active_ref_primary)
  ) else $error("status pin not showing active reference");

  refdet_pin_a: assert property (
    stat_sel == STAT_SEL_REFDET |=> STATUS_PIN == $past(STAT_IN.ref_freq_detect)
  ) else $error("status pin not showing reference detector");

  activity_flags_a: assert property (
    stat_view[B_PRI_ACT] == STAT_IN.primary_ref_activity
    && stat_view[B_SEC_ACT] == STAT_IN.secondary_ref_activity
  ) else $error("activity flags do not follow inputs");

  cd_hold_a: assert property (
    !cd_sample |=> $stable(cd_swap_reg) && $stable(cd_buf_reg) && $stable(cd_aux_reg)
  ) else $error("configuration pins resampled outside power-up");

  auto_ref_a: assert property (
    !osc_ovr && ref_src && ref_cfg_reg[B_SEC_CHOOSE:B_PRI_CHOOSE] == 2'h3
    |=> REF_SEL_OUT.auto_sel && REF_SEL_OUT.pri_en
  ) else $error("automatic reference choice not selected");

  osc_override_a: assert property (
    osc_ovr |=> REF_SEL_OUT.osc_sel && !REF_SEL_OUT.pri_en && !REF_SEL_OUT.sec_en
  ) else $error("oscillator override did not win");

  div_one_a: assert property (
    div_field(out1_cfg_reg, B_OUT_DIV_LO) == 7'h20 |=> OUT_DIV.ratio == 7'h01 && OUT_DIV.lag_half == 8'h00
  ) else $error("code for divide by one decoded wrongly");

  div_max_a: assert property (
    div_field(fb_cfg_reg, B_FB_DIV_LO) == 7'h1f |=> FB_DIV.ratio == 7'h50 && FB_DIV.lag_half == 8'h8c
  ) else $error("largest divide decoded wrongly");

endmodule // csr_regs

// file: tb/csr_host_model.sv
`timescale 1ns/1ps
module csr_host_model (
  // Clock
  input wire logic sys_clk,
  // Link pins, static levels in pin mode
  output logic spi_clk,
  output logic spi_le,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_clk = 1'b0;
    spi_le = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Levels held three cycles so the synchroniser never misses an edge
  task automatic frame(input logic [3:0] addr, input logic [27:0] data, input int nbits,
                       output logic [31:0] rd);
    logic [31:0] word;
    word = {data, addr};
    rd = 32'h0;
    spi_le = 1'b0;
    wait_clk(3);
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = word[i];
      wait_clk(3);
      rd[i] = spi_miso;
      spi_clk = 1'b1;
      wait_clk(3);
      spi_clk = 1'b0;
    end
    wait_clk(3);
    spi_le = 1'b1;
    // Released data line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
    wait_clk(6);
  endtask

  // Pin mode: swap and buffer-type pins static, third pin grounded
  task automatic set_pins(input logic swap, input logic btype);
    spi_clk = swap;
    spi_mosi = btype;
    spi_le = 1'b0;
  endtask
endmodule // csr_host_model

// file: tb/csr_regs_tb.sv
`timescale 1ns/1ps
module csr_regs_tb
  import csr_pkg::*;
;
  localparam logic [2:0] REV = 3'h5; // Arbitrary value
  localparam logic [27:0] RDATA [7] = '{28'h0000023, 28'h2000025, 28'h3000028, 28'h100002c, 28'h000003c,
    28'h000000c, 28'h000000c};
  localparam logic [6:0] RPIN = 7'h35;
  localparam logic [3:0] RSEL [7] = '{4'h0, 4'h8, 4'h4, 4'he, 4'h1, 4'h8, 4'h4};
  localparam logic [1:0] RTYPE [7] = '{2'h3, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  localparam logic [1:0] ROBUF [7] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h0, 2'h0};
  localparam logic [6:0] DCODE [9] = '{7'h20, 7'h40, 7'h41, 7'h42, 7'h43, 7'h00, 7'h01, 7'h1f, 7'h60};
  localparam logic [6:0] DRAT [9] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h04, 7'h06, 7'h50, 7'h00};
  localparam logic [7:0] DLAG [9] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h1d, 8'h2a, 8'h8c, 8'h00};

  logic sys_clk, nrst, mode_select, aux_sel, ref_sel, pd_pin_n;
  logic spi_clk, spi_le, spi_mosi, spi_miso;
  logic status_pin, power_down, reset_assert, hold_assert, test_mode_en, io_block_disable;
  logic divider_swap, aux_mux_sel;
  logic [1:0] ref_input_type, out_buffer_type;
  csr_stat_s stat;
  csr_refsel_s ref_sel_out;
  csr_div_s out_div, fb_div;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  csr_regs #(.REVISION(REV)) csr_regs_i (
    .SYS_CLK(sys_clk), .NRST(nrst), .MODE_SELECT(mode_select), .SPI_CLK(spi_clk), .SPI_LE(spi_le),
    .SPI_MOSI(spi_mosi), .SPI_MISO(spi_miso), .AUX_SEL(aux_sel), .REF_SEL(ref_sel), .PD_PIN_N(pd_pin_n),
    .STAT_IN(stat), .STATUS_PIN(status_pin), .POWER_DOWN(power_down), .RESET_ASSERT(reset_assert),
    .HOLD_ASSERT(hold_assert), .TEST_MODE_EN(test_mode_en), .IO_BLOCK_DISABLE(io_block_disable),
    .REF_SEL_OUT(ref_sel_out), .REF_INPUT_TYPE(ref_input_type), .OUT_BUFFER_TYPE(out_buffer_type),
    .DIVIDER_SWAP(divider_swap), .AUX_MUX_SEL(aux_mux_sel), .OUT_DIV(out_div), .FB_DIV(fb_div)
  );

  csr_host_model csr_host_model_i (
    .sys_clk(sys_clk), .spi_clk(spi_clk), .spi_le(spi_le), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );

  always #10 sys_clk = ~sys_clk;

  task automatic end_sim();
    $display("Totals: %0d comparisons, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Frames take about 200 cycles; the full run needs well under half of this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] addr, input logic [27:0] data);
    logic [31:0] rd;
    csr_host_model_i.frame(addr, data, 32, rd);
  endtask

  // Point readback at a register, then shift it out on the next frame
  task automatic rd_chk(input string what, input logic [3:0] addr, input logic [27:0] exp);
    logic [31:0] w;
    csr_host_model_i.frame(4'he, {24'h0, addr}, 32, w);
    csr_host_model_i.frame(4'he, {24'h0, addr}, 32, w);
    chk(what, {exp, addr}, w);
  endtask

  task automatic t_reset();
    chk("power_down", 1'b0, power_down);
    chk("reset_hold", 2'h0, {reset_assert, hold_assert});
    chk("test_io", 2'h0, {test_mode_en, io_block_disable});
    rd_chk("stat_rst", 4'hc, 28'h0001580);
    $display("done reset");
  endtask

  task automatic t_flags();
    stat = 7'h54;
    rd_chk("flags_a", 4'hc, 28'h40015d0);
    stat = 7'h28;
    rd_chk("flags_b", 4'hc, 28'h20015a0);
    $display("done flags");
  endtask

  task automatic t_ctrl();
    stat = 7'h7c;
    wr(4'hc, 28'hfffffff);
    chk("test_io_on", 2'h3, {test_mode_en, io_block_disable});
    rd_chk("stat_ones", 4'hc, 28'h7fef7f0);
    stat = 7'h0;
    wr(4'hc, 28'h0002180);
    chk("test_io_off", 2'h0, {test_mode_en, io_block_disable});
    wr(4'hc, 28'h0000100);
    chk("pd_bit", 1'b1, power_down);
    wr(4'hb, 28'h0000000);
    wr(4'hc, 28'h0000080);
    chk("reset_sel", 2'h2, {reset_assert, hold_assert});
    wr(4'hb, 28'h2000000);
    wr(4'hc, 28'h0000080);
    chk("hold_sel", 2'h1, {reset_assert, hold_assert});
    wr(4'hc, 28'h0000180);
    chk("normal", 3'h0, {reset_assert, hold_assert, power_down});
    pd_pin_n = 1'b0;
    tick(3);
    chk("pd_pin", 1'b1, power_down);
    pd_pin_n = 1'b1;
    tick(3);
    $display("done controls");
  endtask

  task automatic t_stpin();
    stat.ref_freq_detect = 1'b1;
    tick(3);
    chk("det_hi", 1'b1, status_pin);
    stat.ref_freq_detect = 1'b0;
    stat.active_ref_primary = 1'b1;
    tick(3);
    chk("det_lo", 1'b0, status_pin);
    wr(4'hc, 28'h0100180);
    chk("act_hi", 1'b1, status_pin);
    stat.active_ref_primary = 1'b0;
    stat.ref_freq_detect = 1'b1;
    tick(3);
    chk("act_lo", 1'b0, status_pin);
    stat = 7'h0;
    $display("done status pin");
  endtask

  task automatic t_refsel();
    for (int i = 0; i < 7; i++) begin
      ref_sel = RPIN[i];
      wr(4'h0, RDATA[i]);
      chk("ref_sel", RSEL[i], ref_sel_out);
      chk("in_type", RTYPE[i], ref_input_type);
      chk("obuf_low", ROBUF[i], out_buffer_type);
    end
    $display("done reference select");
  endtask

  task automatic t_div();
    logic [15:0] exp;
    for (int i = 0; i < 9; i++) begin
      exp = {i != 8, DRAT[i], DLAG[i]};
      wr(4'h1, {8'h0, DCODE[i], 13'h0});
      wr(4'hb, {16'h0, DCODE[i], 5'h0});
      chk("out_div", exp, out_div);
      chk("fb_div", exp, fb_div);
    end
    $display("done dividers");
  endtask

  task automatic t_refuse();
    logic [31:0] w;
    wr(4'h5, 28'habcdef1);
    rd_chk("unmapped", 4'h5, 28'h0);
    csr_host_model_i.frame(4'hc, 28'h0000000, 31, w);
    chk("short_frame", 1'b0, power_down);
    rd_chk("stat_kept", 4'hc, 28'h0101580);
    $display("done refusals");
  endtask

  task automatic t_pin();
    wr(4'h0, 28'he000000);
    mode_select = 1'b0;
    tick(1);
    csr_host_model_i.set_pins(1'b1, 1'b1);
    aux_sel = 1'b1;
    pd_pin_n = 1'b0;
    tick(4);
    pd_pin_n = 1'b1;
    tick(4);
    chk("pin_obuf", 2'h3, out_buffer_type);
    chk("pin_swap_aux", 2'h3, {divider_swap, aux_mux_sel});
    csr_host_model_i.set_pins(1'b0, 1'b0);
    aux_sel = 1'b0;
    tick(6);
    chk("pin_hold", 4'hf, {out_buffer_type, divider_swap, aux_mux_sel});
    nrst = 1'b0;
    csr_host_model_i.set_pins(1'b1, 1'b0);
    tick(12);
    nrst = 1'b1;
    tick(3);
    chk("pin_reset", 4'h2, {out_buffer_type, divider_swap, aux_mux_sel});
    $display("done pin mode");
  endtask

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    mode_select = 1'b1;
    aux_sel = 1'b0;
    ref_sel = 1'b0;
    pd_pin_n = 1'b1;
    stat = 7'h0;
    tick(12);
    nrst = 1'b1;
    tick(2);
    t_reset();
    t_flags();
    t_ctrl();
    t_stpin();
    t_refsel();
    t_div();
    t_refuse();
    t_pin();
    end_sim();
  end
endmodule // csr_regs_tb
